// ### src/gpab_map.svh
`ifndef GPAB_MAP_SVH
`define GPAB_MAP_SVH

// register indices on the plain register port
`define GPAB_ADDR_W          4
`define GPAB_OFF_PA_PINS     4'h0
`define GPAB_OFF_PA_LAT      4'h1
`define GPAB_OFF_PA_DIR      4'h2
`define GPAB_OFF_PB_PINS     4'h3
`define GPAB_OFF_PB_LAT      4'h4
`define GPAB_OFF_PB_DIR      4'h5
`define GPAB_OFF_MAIN_IRQ    4'h6
`define GPAB_OFF_SECOND_IRQ  4'h7
`define GPAB_OFF_ANALOG_CFG  4'h8
`define GPAB_OFF_CMP_CTRL    4'h9
`define GPAB_OFF_CMP_VREF    4'hA

// field positions
`define GPAB_BIT_CHANGE_FLAG 0
`define GPAB_BIT_PULLUP_N    7
`define GPAB_BIT_ANALOG_DFLT 1
`define GPAB_BIT_CCP2_SEL    0

// reset values
`define GPAB_RST_DIR         8'hFF
`define GPAB_RST_LAT         8'h00
`define GPAB_RST_MAIN_IRQ    8'h00
`define GPAB_RST_SECOND_IRQ  8'hF5
`define GPAB_RST_ANALOG_CFG  8'h00
`define GPAB_RST_CMP_CTRL    8'h07
`define GPAB_RST_CMP_VREF    8'h00

// implemented-bit masks, oscillator pin mask for port a and change-detection pin mask for port b
`define GPAB_MASK_ANALOG_CFG 8'h3F
`define GPAB_MASK_CMP_VREF   8'hEF
`define GPAB_MASK_SECOND_IRQ 8'hF5
`define GPAB_MASK_PA_OSC     8'h3F
`define GPAB_MASK_CHANGE_PIN 8'hF0

`endif

// ### src/gpab_pkg.sv
package gpab_pkg;
  typedef logic [7:0] gpab_byte_type;
  typedef logic [3:0] gpab_addr_type;
endpackage

// ### src/gpab_ports.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "gpab_map.svh"

module gpab_ports (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              por,
  // register port
  input  wire gpab_pkg::gpab_addr_type reg_addr,
  input  wire gpab_pkg::gpab_byte_type reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              reg_rd_is_move_dest,
  input  wire logic              reg_wr_is_move_dest,
  output gpab_pkg::gpab_byte_type reg_rdata,
  // configuration straps and ccp2 output
  input  wire gpab_pkg::gpab_byte_type config_byte_3_high,
  input  wire logic              osc_pins_are_io,
  input  wire logic              ccp2_out,
  // port a pins
  input  wire gpab_pkg::gpab_byte_type port_a_in,
  output gpab_pkg::gpab_byte_type port_a_out,
  output gpab_pkg::gpab_byte_type port_a_oe_n,
  // port b pins
  input  wire gpab_pkg::gpab_byte_type port_b_in,
  output gpab_pkg::gpab_byte_type port_b_out,
  output gpab_pkg::gpab_byte_type port_b_oe_n,
  output gpab_pkg::gpab_byte_type port_b_pullup_en,
  // status
  output logic                   pin_change_flag,
  output logic                   wake_request,
  output logic                   ccp2_on_pin3
);
  import gpab_pkg::*;

  gpab_byte_type pa_lat_reg, pa_dir_reg, pb_lat_reg, pb_dir_reg;
  gpab_byte_type pa_meta_reg, pa_sync_reg, pb_meta_reg, pb_sync_reg;
  gpab_byte_type snapshot_reg, analog_cfg_reg, cmp_ctrl_reg, cmp_vref_reg;
  gpab_byte_type second_irq_reg, main_irq_reg, rdata_next;
  logic          pullup_n_reg, pb_analog_reg, ccp2_sel_reg, por_seen_reg;
  logic          mismatch, pb_access;
  logic [1:0]    snap_fill_reg;
  gpab_byte_type pb_digital_mask, pa_osc_mask;

  function automatic logic hit(input gpab_addr_type a);
    hit = (reg_addr == a);
  endfunction

  // two-flop synchronisers; first stage only feeds the second
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pa_meta_reg <= 8'h00;
      pa_sync_reg <= 8'h00;
      pb_meta_reg <= 8'h00;
      pb_sync_reg <= 8'h00;
    end else begin
      pa_meta_reg <= port_a_in;
      pa_sync_reg <= pa_meta_reg;
      pb_meta_reg <= port_b_in;
      pb_sync_reg <= pb_meta_reg;
    end
  end

  // straps are caught after release, since async reset takes constants only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      por_seen_reg  <= 1'b1;
      pb_analog_reg <= 1'b1;
      ccp2_sel_reg  <= 1'b1;
    end else begin
      por_seen_reg <= 1'b0;
      if (por_seen_reg && por) begin
        pb_analog_reg <= ~config_byte_3_high[`GPAB_BIT_ANALOG_DFLT];
      end
      if (por_seen_reg) begin
        ccp2_sel_reg <= config_byte_3_high[`GPAB_BIT_CCP2_SEL];
      end
    end
  end

  assign pa_osc_mask = osc_pins_are_io ? 8'hFF : `GPAB_MASK_PA_OSC;
  assign pb_digital_mask = pb_analog_reg ? 8'hE0 : 8'hFF;
  assign pb_access = (reg_wr && hit(`GPAB_OFF_PB_PINS) && !reg_wr_is_move_dest)
                   || (reg_rd && hit(`GPAB_OFF_PB_PINS));

  // data latches and directions
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pa_lat_reg <= `GPAB_RST_LAT;
      pa_dir_reg <= `GPAB_RST_DIR;
      pb_lat_reg <= `GPAB_RST_LAT;
      pb_dir_reg <= `GPAB_RST_DIR;
    end else if (reg_wr) begin
      if (hit(`GPAB_OFF_PA_PINS) || hit(`GPAB_OFF_PA_LAT)) begin
        pa_lat_reg <= reg_wdata;
      end
      if (hit(`GPAB_OFF_PA_DIR)) begin
        pa_dir_reg <= reg_wdata;
      end
      if (hit(`GPAB_OFF_PB_PINS) || hit(`GPAB_OFF_PB_LAT)) begin
        pb_lat_reg <= reg_wdata;
      end
      if (hit(`GPAB_OFF_PB_DIR)) begin
        pb_dir_reg <= reg_wdata;
      end
    end
  end

  // control registers; pull-up bit held off on power-on reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      second_irq_reg <= `GPAB_RST_SECOND_IRQ;
      pullup_n_reg   <= 1'b1;
      analog_cfg_reg <= `GPAB_RST_ANALOG_CFG;
      cmp_ctrl_reg   <= `GPAB_RST_CMP_CTRL;
      cmp_vref_reg   <= `GPAB_RST_CMP_VREF;
    end else if (por) begin
      pullup_n_reg   <= 1'b1;
    end else if (reg_wr) begin
      if (hit(`GPAB_OFF_SECOND_IRQ)) begin
        second_irq_reg <= reg_wdata & `GPAB_MASK_SECOND_IRQ;
        pullup_n_reg   <= reg_wdata[`GPAB_BIT_PULLUP_N];
      end
      if (hit(`GPAB_OFF_ANALOG_CFG)) begin
        analog_cfg_reg <= reg_wdata & `GPAB_MASK_ANALOG_CFG;
      end
      if (hit(`GPAB_OFF_CMP_CTRL)) begin
        cmp_ctrl_reg <= reg_wdata;
      end
      if (hit(`GPAB_OFF_CMP_VREF)) begin
        cmp_vref_reg <= reg_wdata & `GPAB_MASK_CMP_VREF;
      end
    end
  end

  // snapshot of pins 7..4, refreshed by a port b pin read or a pin write that is not a move destination; it also tracks
  // the pins while the synchroniser fills, so idle-high pins flag nothing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      snapshot_reg <= 8'h00;
    end else if (pb_access || snap_fill_reg != 2'h0) begin
      snapshot_reg <= pb_sync_reg & `GPAB_MASK_CHANGE_PIN;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      snap_fill_reg <= 2'h3;
    end else if (snap_fill_reg != 2'h0) begin
      snap_fill_reg <= snap_fill_reg - 2'h1;
    end
  end

  // only inputs among pins 7..4 take part
  assign mismatch = (snap_fill_reg == 2'h0)
                 && |((pb_sync_reg ^ snapshot_reg) & pb_dir_reg
                      & `GPAB_MASK_CHANGE_PIN);

  // set beats clear so a change in the clearing cycle is kept
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      main_irq_reg <= `GPAB_RST_MAIN_IRQ;
    end else if (mismatch) begin
      main_irq_reg[`GPAB_BIT_CHANGE_FLAG] <= 1'b1;
    end else if (reg_wr && hit(`GPAB_OFF_MAIN_IRQ)) begin
      main_irq_reg <= reg_wdata;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      `GPAB_OFF_PA_PINS:    rdata_next = pa_sync_reg & pa_osc_mask;
      `GPAB_OFF_PA_LAT:     rdata_next = pa_lat_reg & pa_osc_mask;
      `GPAB_OFF_PA_DIR:     rdata_next = pa_dir_reg & pa_osc_mask;
      `GPAB_OFF_PB_PINS:    rdata_next = pb_sync_reg & pb_digital_mask;
      `GPAB_OFF_PB_LAT:     rdata_next = pb_lat_reg;
      `GPAB_OFF_PB_DIR:     rdata_next = pb_dir_reg;
      `GPAB_OFF_MAIN_IRQ:   rdata_next = main_irq_reg;
      `GPAB_OFF_SECOND_IRQ: rdata_next = {pullup_n_reg, second_irq_reg[6:0]};
      `GPAB_OFF_ANALOG_CFG: rdata_next = analog_cfg_reg;
      `GPAB_OFF_CMP_CTRL:   rdata_next = cmp_ctrl_reg;
      `GPAB_OFF_CMP_VREF:   rdata_next = cmp_vref_reg;
      default:              rdata_next = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata        <= 8'h00;
      port_a_out       <= 8'h00;
      port_a_oe_n      <= 8'hFF;
      port_b_out       <= 8'h00;
      port_b_oe_n      <= 8'hFF;
      port_b_pullup_en <= 8'h00;
      pin_change_flag  <= 1'b0;
      wake_request     <= 1'b0;
      ccp2_on_pin3     <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rdata_next : 8'h00;
      port_a_out <= {pa_lat_reg[7:5], 1'b0, pa_lat_reg[3:0]};
      port_a_oe_n <= {pa_dir_reg[7:5], pa_dir_reg[4] | pa_lat_reg[4],
                      pa_dir_reg[3:0]} | ~pa_osc_mask;
      port_b_out <= (ccp2_sel_reg == 1'b0)
                  ? {pb_lat_reg[7:4], ccp2_out, pb_lat_reg[2:0]}
                  : pb_lat_reg;
      port_b_oe_n <= pb_dir_reg;
      port_b_pullup_en <= pullup_n_reg ? 8'h00 : pb_dir_reg;
      pin_change_flag  <= main_irq_reg[`GPAB_BIT_CHANGE_FLAG];
      wake_request     <= main_irq_reg[`GPAB_BIT_CHANGE_FLAG];
      ccp2_on_pin3     <= ~ccp2_sel_reg;
    end
  end

  // checks
  property p_drive_follows_dir;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> port_b_oe_n == $past(pb_dir_reg);
  endproperty
  a_drive_follows_dir: assert property (p_drive_follows_dir)
    else $error("port b enable does not follow direction");

  property p_pullup_off_outputs;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> (port_b_pullup_en & ~$past(pb_dir_reg)) == 8'h00;
  endproperty
  a_pullup_off_outputs: assert property (p_pullup_off_outputs)
    else $error("pull-up active on output pin");

  property p_por_pullup;
    @(posedge ref_clk) disable iff (reset)
      por |=> ##1 port_b_pullup_en == 8'h00;
  endproperty
  a_por_pullup: assert property (p_por_pullup)
    else $error("pull-up on after power-on reset");

  property p_lat_write;
    @(posedge ref_clk) disable iff (reset)
      reg_wr && hit(`GPAB_OFF_PB_LAT) |=> pb_lat_reg == $past(reg_wdata);
  endproperty
  a_lat_write: assert property (p_lat_write)
    else $error("port b latch not written");

  property p_flag_sets;
    @(posedge ref_clk) disable iff (reset)
      mismatch |=> main_irq_reg[`GPAB_BIT_CHANGE_FLAG] ##1 pin_change_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("change flag not set on mismatch");

  property p_snapshot_refresh;
    @(posedge ref_clk) disable iff (reset)
      pb_access |=> snapshot_reg == ($past(pb_sync_reg) & 8'hF0);
  endproperty
  a_snapshot_refresh: assert property (p_snapshot_refresh)
    else $error("snapshot not refreshed");

  property p_outputs_excluded;
    @(posedge ref_clk) disable iff (reset)
      (pb_dir_reg[7:4] == 4'h0) |-> !mismatch;
  endproperty
  a_outputs_excluded: assert property (p_outputs_excluded)
    else $error("output pin caused mismatch");

  property p_unmapped_zero;
    @(posedge ref_clk) disable iff (reset)
      reg_rd && reg_addr > `GPAB_OFF_CMP_VREF |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_pa4_never_high;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> port_a_out[4] == 1'b0;
  endproperty
  a_pa4_never_high: assert property (p_pa4_never_high)
    else $error("open-drain pin driven high");

  property p_wake_follows_flag;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> wake_request == $past(main_irq_reg[`GPAB_BIT_CHANGE_FLAG]);
  endproperty
  a_wake_follows_flag: assert property (p_wake_follows_flag)
    else $error("wake request does not follow change flag");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (reset)
      main_irq_reg[`GPAB_BIT_CHANGE_FLAG]
        && !(reg_wr && hit(`GPAB_OFF_MAIN_IRQ))
        |=> main_irq_reg[`GPAB_BIT_CHANGE_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("change flag dropped without a clear");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (reset)
      reg_wr && hit(`GPAB_OFF_MAIN_IRQ) && !mismatch
        && !reg_wdata[`GPAB_BIT_CHANGE_FLAG]
        |=> !main_irq_reg[`GPAB_BIT_CHANGE_FLAG];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("change flag not cleared after mismatch ended");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_osc_pins_released;
    @(posedge ref_clk) disable iff (reset)
      !osc_pins_are_io |=> port_a_oe_n[7:6] == 2'b11;
  endproperty
  a_osc_pins_released: assert property (p_osc_pins_released)
    else $error("oscillator pins driven as port pins");

  property p_analog_reads_zero;
    @(posedge ref_clk) disable iff (reset)
      reg_rd && hit(`GPAB_OFF_PB_PINS) && pb_analog_reg
        |=> reg_rdata[4:0] == 5'h00;
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero)
    else $error("analog pin read not zero");

  property p_move_no_refresh;
    @(posedge ref_clk) disable iff (reset)
      reg_wr && reg_wr_is_move_dest && hit(`GPAB_OFF_PB_PINS) && !reg_rd
        && snap_fill_reg == 2'h0
        |=> snapshot_reg == $past(snapshot_reg);
  endproperty
  a_move_no_refresh: assert property (p_move_no_refresh)
    else $error("move destination write refreshed snapshot");

  property p_pa4_release;
    @(posedge ref_clk) disable iff (reset)
      pa_lat_reg[4] |=> port_a_oe_n[4];
  endproperty
  a_pa4_release: assert property (p_pa4_release)
    else $error("open-drain pin not released for latch one");

  property p_ccp2_route;
    @(posedge ref_clk) disable iff (reset)
      !ccp2_sel_reg |=> port_b_out[3] == $past(ccp2_out);
  endproperty
  a_ccp2_route: assert property (p_ccp2_route)
    else $error("ccp2 output not routed to pin3");

  property p_pullup_off;
    @(posedge ref_clk) disable iff (reset)
      pullup_n_reg |=> port_b_pullup_en == 8'h00;
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up on while control bit is high");

  c_mismatch: cover property (@(posedge ref_clk) disable iff (reset)
    mismatch ##1 pb_access);
  c_wake: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(wake_request));
  c_pullup: cover property (@(posedge ref_clk) disable iff (reset)
    port_b_pullup_en != 8'h00);
  c_move: cover property (@(posedge ref_clk) disable iff (reset)
    reg_wr && reg_wr_is_move_dest && hit(`GPAB_OFF_PB_PINS));

endmodule // gpab_ports

// ### test/gpab_pin_model.sv
`timescale 1ns/10ps

module gpab_pin_model (
  // clock
  input  wire logic              ref_clk,
  // design side of the pins
  input  wire gpab_pkg::gpab_byte_type drv_out,
  input  wire gpab_pkg::gpab_byte_type drv_oe_n,
  input  wire gpab_pkg::gpab_byte_type pull_en,
  // board side
  input  wire gpab_pkg::gpab_byte_type ext_val,
  input  wire gpab_pkg::gpab_byte_type ext_en,
  output gpab_pkg::gpab_byte_type level
);
  import gpab_pkg::*;

  gpab_byte_type float_reg = 8'h55;

  // an undriven pin toggles, so a stale level never passes for a real one
  always @(posedge ref_clk) begin
    float_reg <= ~float_reg;
  end

  // the block's own driver wins over the board
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!drv_oe_n[i])
        level[i] = drv_out[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (pull_en[i])
        level[i] = 1'b1;
      else
        level[i] = float_reg[i];
    end
  end
endmodule // gpab_pin_model

// ### test/testbench.sv
`timescale 1ns/10ps
`include "gpab_map.svh"

module testbench;
  import gpab_pkg::*;

  logic          ref_clk = 1'b0;
  logic          reset = 1'b1;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic          wr_mv = 1'b0;
  logic          por = 1'b1;
  logic          ccp2_o = 1'b0;
  logic          osc_io = 1'b1;
  logic          rd_seen = 1'b0;
  logic          flag, wake, ccp2_pin3;
  gpab_addr_type reg_addr = 4'h0;
  gpab_byte_type reg_wdata = 8'h00;
  gpab_byte_type ext_b = 8'hFF;
  gpab_byte_type ext_en_b = 8'hFF;
  gpab_byte_type cfg = 8'h00;
  gpab_byte_type reg_rdata, pa_out, pa_oe_n, pa_in;
  gpab_byte_type pb_out, pb_oe_n, pb_in, pb_pu, v;
  gpab_byte_type exp_q[$];
  int            error_cnt = 0;
  int            check_count = 0;
  integer        seed = 32'h960811d4;

  always #10 ref_clk = ~ref_clk;

  gpab_ports dut (.ref_clk(ref_clk), .reset(reset), .por(por),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_is_move_dest(1'b0),
    .reg_wr_is_move_dest(wr_mv), .reg_rdata(reg_rdata),
    .config_byte_3_high(cfg), .osc_pins_are_io(osc_io),
    .ccp2_out(ccp2_o), .port_a_in(pa_in), .port_a_out(pa_out),
    .port_a_oe_n(pa_oe_n), .port_b_in(pb_in), .port_b_out(pb_out),
    .port_b_oe_n(pb_oe_n), .port_b_pullup_en(pb_pu),
    .pin_change_flag(flag), .wake_request(wake),
    .ccp2_on_pin3(ccp2_pin3));

  gpab_pin_model pins_a (.ref_clk(ref_clk), .drv_out(pa_out),
    .drv_oe_n(pa_oe_n), .pull_en(8'h00), .ext_val(8'hA5),
    .ext_en(8'hFF), .level(pa_in));
  gpab_pin_model pins_b (.ref_clk(ref_clk), .drv_out(pb_out),
    .drv_oe_n(pb_oe_n), .pull_en(pb_pu), .ext_val(ext_b),
    .ext_en(ext_en_b), .level(pb_in));

  task automatic chk(input gpab_byte_type got, input gpab_byte_type exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input gpab_addr_type a, input gpab_byte_type d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input gpab_addr_type a, input gpab_byte_type e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic settle;
    repeat (6) @(posedge ref_clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_seen)
      chk(reg_rdata, exp_q.pop_front());
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    por <= 1'b0;
    settle();
    rd(`GPAB_OFF_PA_DIR, 8'hFF);
    rd(`GPAB_OFF_MAIN_IRQ, 8'h00);
    rd(`GPAB_OFF_PB_DIR, 8'hFF);
    rd(`GPAB_OFF_SECOND_IRQ, 8'hF5);
    rd(`GPAB_OFF_CMP_CTRL, 8'h07);
    rd(`GPAB_OFF_ANALOG_CFG, 8'h00);
    rd(`GPAB_OFF_CMP_VREF, 8'h00);
    rd(4'hB, 8'h00);
    chk(pb_pu, 8'h00);
    chk({7'h00, ccp2_pin3}, 8'h01);
    rd(`GPAB_OFF_PB_PINS, 8'hE0);
    $display("reset test done");
    v = $random(seed);
    wr(`GPAB_OFF_PB_LAT, v);
    rd(`GPAB_OFF_PB_LAT, v);
    wr(`GPAB_OFF_PB_DIR, 8'h0F);
    ext_en_b <= 8'h0F;
    ccp2_o <= ~v[3];
    wr(`GPAB_OFF_SECOND_IRQ, 8'h75);
    settle();
    chk(pb_oe_n, 8'h0F);
    chk(pb_out & 8'hF0, v & 8'hF0);
    chk(pb_out & 8'h08, {4'h0, ~v[3], 3'h0});
    chk(pb_pu, 8'h0F);
    rd(`GPAB_OFF_PB_PINS, {v[7:5], 5'h00});
    $display("latch test done");
    // pin 5 drives from the latch, so its change must not count
    wr(`GPAB_OFF_PB_DIR, 8'hDF);
    ext_en_b <= 8'hDF;
    wr(`GPAB_OFF_PB_LAT, 8'h00);
    settle();
    rd(`GPAB_OFF_PB_PINS, 8'hC0);
    wr(`GPAB_OFF_MAIN_IRQ, 8'h00);
    wr(`GPAB_OFF_PB_LAT, 8'h20);
    ext_b <= 8'hFE;
    settle();
    rd(`GPAB_OFF_MAIN_IRQ, 8'h00);
    ext_b <= 8'h7E;
    settle();
    chk({7'h00, flag}, 8'h01);
    chk({7'h00, wake}, 8'h01);
    wr(`GPAB_OFF_MAIN_IRQ, 8'h00);
    rd(`GPAB_OFF_MAIN_IRQ, 8'h01);
    wr_mv <= 1'b1;
    wr(`GPAB_OFF_PB_PINS, 8'h00);
    wr_mv <= 1'b0;
    wr(`GPAB_OFF_MAIN_IRQ, 8'h00);
    rd(`GPAB_OFF_MAIN_IRQ, 8'h01);
    rd(`GPAB_OFF_PB_PINS, 8'h40);
    rd(`GPAB_OFF_MAIN_IRQ, 8'h01);
    wr(`GPAB_OFF_MAIN_IRQ, 8'h00);
    rd(`GPAB_OFF_MAIN_IRQ, 8'h00);
    $display("change test done");
    wr(`GPAB_OFF_PA_DIR, 8'h00);
    wr(`GPAB_OFF_PA_LAT, 8'hFF);
    settle();
    chk({6'h00, pa_out[4], pa_oe_n[4]}, 8'h01);
    wr(`GPAB_OFF_PA_LAT, 8'hC3);
    settle();
    chk({6'h00, pa_out[4], pa_oe_n[4]}, 8'h00);
    // oscillator owns bits 7:6 now: they read zero and are not driven
    osc_io <= 1'b0;
    settle();
    rd(`GPAB_OFF_PA_LAT, 8'h03);
    chk(pa_oe_n & 8'hC0, 8'hC0);
    wr(`GPAB_OFF_PA_DIR, 8'hFF);
    rd(`GPAB_OFF_PA_DIR, 8'h3F);
    chk(pb_pu, 8'hDF);
    $display("port a test done");
    // second power-on: straps ask for digital pins and ccp2 elsewhere
    cfg <= 8'h03;
    ccp2_o <= 1'b1;
    ext_en_b <= 8'hFF;
    ext_b <= 8'h3C;
    por <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    por <= 1'b0;
    settle();
    chk(pb_pu, 8'h00);
    chk({7'h00, ccp2_pin3}, 8'h00);
    chk(pb_out & 8'h08, 8'h00);
    rd(`GPAB_OFF_PB_PINS, 8'h3C);
    rd(`GPAB_OFF_MAIN_IRQ, 8'h00);
    $display("power-on test done");
    settle();
    summarize();
  end
endmodule // testbench
